// >>> cfsb_pkg.sv
// package: field layout, frame constants and timing counts for the config and fault status bank
package cfsb_pkg;
  // serial frame: 2 address/mode bits, 22 data bits
  localparam int FRAME_BITS = 24;
  localparam int WORD_BITS = 22;
  localparam logic [1:0] ADDR_CW0 = 2'h0;
  localparam logic [1:0] ADDR_CW1 = 2'h1;
  localparam logic [1:0] ADDR_CW2 = 2'h2;
  localparam int CLR_BIT = 21;
  // third control word field positions
  localparam int F_OLT_LO = 0;
  localparam int F_LOCK = 4;
  localparam int F_REC = 5;
  localparam int F_PU = 6;
  localparam int F_TOUT = 7;
  localparam int F_RESET_THRESHOLD_SELECT_LOWER = 8;
  localparam int F_RESET_THRESHOLD_SELECT_UPPER = 9;
  localparam int F_IC_LO = 10;
  localparam int F_SLOPE = 18;
  localparam int F_RELSD = 19;
  localparam int F_REGULATOR_CURRENT_SUPERVISION_DISABLE = 20;
  // status word field positions
  localparam int S_OL_LO = 0;
  localparam int S_OC_LO = 5;
  localparam int S_SHT = 12;
  localparam int S_WU_LO = 13;
  localparam int S_EXTWU = 17;
  localparam int S_BUSWU = 18;
  localparam int S_COLD = 19;
  localparam logic [21:0] STATUS_RESET = 22'h000000;
  localparam logic [21:0] CTRL_RESET = 22'h000000;
  // wake filter codes
  localparam logic [1:0] WF_STATIC = 2'h0;
  localparam logic [1:0] WF_T2_SHORT = 2'h1;
  localparam logic [1:0] WF_T2_LONG = 2'h2;
  localparam logic [1:0] WF_T1_LONG = 2'h3;
  // timing at the 25 MHz clock
  localparam int CLK_MHZ = 25;
  localparam int FILT_STATIC_US = 64;
  localparam int FILT_CYCLIC_US = 16;
  localparam int DELAY_SHORT_US = 80;
  localparam int DELAY_LONG_US = 800;
  localparam int FILT_STATIC_CYC = FILT_STATIC_US * CLK_MHZ;
  localparam int FILT_CYCLIC_CYC = FILT_CYCLIC_US * CLK_MHZ;
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;
  localparam int DELAY_LONG_CYC = DELAY_LONG_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage

// >>> cfsb_wake_if.sv
// interface: wake input filter control and result
`timescale 1ns/10ps
interface cfsb_wake_if;
  logic [7:0] filt_cfg; // two code bits per wake input
  logic [3:0] cycle_start; // sensing cycle start pulse per input
  logic [3:0] raw; // synchronised wake levels
  logic [3:0] filtered; // filtered wake levels
  modport ctrl (output filt_cfg, output cycle_start, output raw, input filtered);
  modport filt (input filt_cfg, input cycle_start, input raw, output filtered);
endinterface

// >>> cfsb_wake_filter.sv
// module: per-input wake filter with static and cyclic sensing
`timescale 1ns/10ps
module cfsb_wake_filter
  import cfsb_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  cfsb_wake_if.filt wk
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_wu
      logic [1:0] code;
      logic [CNT_W-1:0] delay_r; // cycles left before filter arms
      logic [CNT_W-1:0] stab_r; // cycles of steady differing level
      logic [CNT_W-1:0] need; // required stable cycles
      logic out_r;
      assign code = wk.filt_cfg[2*g +: 2];
      // static 64 us, cyclic 16 us
      assign need = (code == WF_STATIC) ? CNT_W'(FILT_STATIC_CYC) : CNT_W'(FILT_CYCLIC_CYC);
      // -------------------------------------------------------
      // arm delay after cycle start: 80 us or 800 us
      // -------------------------------------------------------
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          delay_r <= '0;
        end else if (wk.cycle_start[g] && code != WF_STATIC) begin
          if (code == WF_T2_SHORT) begin
            delay_r <= CNT_W'(DELAY_SHORT_CYC);
          end else begin // timer 2 or timer 1 long delay
            delay_r <= CNT_W'(DELAY_LONG_CYC);
          end
        end else if (delay_r != '0) begin
          delay_r <= delay_r - 1'b1;
        end
      end
      // -------------------------------------------------------
      // stability counter; only runs once armed
      // -------------------------------------------------------
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          stab_r <= '0;
          out_r <= 1'b0;
        end else if (delay_r != '0 || wk.raw[g] == out_r) begin
          stab_r <= '0;
        end else if (stab_r + 1'b1 >= need) begin
          out_r <= wk.raw[g]; // level held long enough
          stab_r <= '0;
        end else begin
          stab_r <= stab_r + 1'b1;
        end
      end
      assign wk.filtered[g] = out_r;
    end
  endgenerate
endmodule

// >>> cfsb_bank.sv
// module: serial-reached configuration decode and diagnostic status word
`timescale 1ns/10ps
module cfsb_bank
  import cfsb_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_di_in,
  output logic spi_do_out,
  input wire logic [3:0] small_highside_openload_in,
  input wire logic main_highside_openload_in,
  input wire logic [3:0] small_highside_overcurrent_in,
  input wire logic main_highside_overcurrent_in,
  input wire logic [1:0] relay_overcurrent_in,
  input wire logic second_regulator_short_in,
  input wire logic [3:0] wake_input_in,
  input wire logic [3:0] wake_cycle_start_in,
  input wire logic external_pin_wake_in,
  input wire logic bus_wake_in,
  input wire logic supply_fault_in,
  output logic [3:0] openload_threshold_high_out,
  output logic main_highside_recovery_out,
  output logic bus_master_pullup_off_out,
  output logic transmit_timeout_off_out,
  output logic [1:0] reset_threshold_out,
  output logic bus_slew_low_out,
  output logic regulator_supervision_on_out,
  output logic outputs_enable_out,
  output logic relay_drivers_enable_out,
  output logic status_clear_out,
  output logic [21:0] status_word_out
);
  // -----------------------------------------------------------
  // input synchronisers: two flops before any logic
  // -----------------------------------------------------------
  logic [2:0] sp_m_r; // first stage: cs_n, clk, di
  logic [2:0] sp_s_r; // second stage
  logic [19:0] ev_m_r; // first stage of fault and wake inputs
  logic [19:0] ev_s_r; // second stage
  logic sclk_d_r; // previous synced serial clock, for edges
  // limitation: each serial level needs two sync flops and a detect cycle,
  // so the serial clock must stay at or below an eighth of the system clock;
  // faster hosts would see merged or missed edges
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sp_m_r <= 3'h1;
      sp_s_r <= 3'h1;
      ev_m_r <= 20'h00000;
      ev_s_r <= 20'h00000;
      sclk_d_r <= 1'b0;
    end else begin
      sp_m_r <= {spi_di_in, spi_clk_in, spi_cs_n_in};
      sp_s_r <= sp_m_r;
      ev_m_r <= {supply_fault_in, bus_wake_in, external_pin_wake_in, wake_input_in,
                 second_regulator_short_in, relay_overcurrent_in,
                 main_highside_overcurrent_in, small_highside_overcurrent_in,
                 main_highside_openload_in, small_highside_openload_in};
      ev_s_r <= ev_m_r;
      sclk_d_r <= sp_s_r[1];
    end
  end
  logic cs_n;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi;
  logic supply_fault;
  assign cs_n = sp_s_r[0];
  assign sdi = sp_s_r[2];
  assign sclk_rise = sp_s_r[1] && !sclk_d_r;
  assign sclk_fall = !sp_s_r[1] && sclk_d_r;
  assign supply_fault = ev_s_r[19];
  // -----------------------------------------------------------
  // serial frame tracking
  // -----------------------------------------------------------
  logic cs_n_d_r; // previous chip select, frame edges
  logic [FRAME_BITS-1:0] shin_r; // bits received so far
  logic [4:0] bitcnt_r; // rising edges seen in frame
  logic [WORD_BITS-1:0] shout_r; // status bits left to send
  logic do_r; // serial data out flop
  logic frame_start;
  logic frame_end;
  logic [1:0] frame_addr;
  assign frame_start = cs_n_d_r && !cs_n;
  assign frame_end = !cs_n_d_r && cs_n;
  assign frame_addr = shin_r[FRAME_BITS-1 -: 2];
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n;
    end
  end
  // -----------------------------------------------------------
  // receive shifter: msb first, sampled on rising clock edge
  // -----------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      shin_r <= '0;
      bitcnt_r <= 5'h00;
    end else if (frame_start) begin
      shin_r <= '0;
      bitcnt_r <= 5'h00;
    end else if (!cs_n && sclk_rise) begin
      // the counter saturates, so an overlong frame never looks complete
      shin_r <= {shin_r[FRAME_BITS-2:0], sdi};
      if (bitcnt_r != 5'h1F) begin
        bitcnt_r <= bitcnt_r + 5'h01;
      end
    end
  end
  // -----------------------------------------------------------
  // status word storage
  // -----------------------------------------------------------
  logic [21:0] status_r; // assembled diagnostic status word
  logic [21:0] stat_snap_r; // snapshot sent during a frame
  logic valid_frame; // full frame completed
  logic clr_cmd; // clear command seen at frame end
  logic cold_pend_r; // power-on event still to be latched
  assign valid_frame = frame_end && (bitcnt_r == 5'(FRAME_BITS));
  // address 1 bit 21 carries the clear command
  assign clr_cmd = valid_frame && (frame_addr == ADDR_CW1) && shin_r[CLR_BIT];
  // -----------------------------------------------------------
  // transmit: status word out when address selects word 0 or 2
  // -----------------------------------------------------------
  // the address bits arrive first, so the status is loaded once both
  // are seen and shifted on the following falling edges
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      shout_r <= '0;
      do_r <= 1'b0;
    end else if (frame_start) begin
      shout_r <= '0;
      do_r <= 1'b0;
    end else if (!cs_n && sclk_fall) begin
      if (bitcnt_r == 5'h02 &&
          (shin_r[1:0] == ADDR_CW0 || shin_r[1:0] == ADDR_CW2)) begin
        do_r <= stat_snap_r[WORD_BITS-1];
        shout_r <= {stat_snap_r[WORD_BITS-2:0], 1'b0};
      end else begin
        do_r <= shout_r[WORD_BITS-1];
        shout_r <= {shout_r[WORD_BITS-2:0], 1'b0};
      end
    end
  end
  // snapshot at frame start so a frame reads one consistent word
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      stat_snap_r <= STATUS_RESET;
    end else if (frame_start) begin
      stat_snap_r <= status_r;
    end
  end
  // -----------------------------------------------------------
  // configuration word: written by a full frame to word 2
  // -----------------------------------------------------------
  // a short or overlong frame never reaches the configuration word
  logic [21:0] ctrl_r;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_r <= CTRL_RESET;
    end else if (valid_frame && frame_addr == ADDR_CW2) begin
      ctrl_r <= shin_r[WORD_BITS-1:0];
    end
  end
  // -----------------------------------------------------------
  // wake filter instance
  // -----------------------------------------------------------
  cfsb_wake_if wk ();
  assign wk.filt_cfg = ctrl_r[F_IC_LO +: 8];
  assign wk.cycle_start = wake_cycle_start_in; // on-chip timer pulse, same clock
  assign wk.raw = ev_s_r[16:13];
  cfsb_wake_filter u_filt (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .wk(wk)
  );
  // -----------------------------------------------------------
  // status flags: sticky faults, live wakes, power-on flag
  // -----------------------------------------------------------
  // each group of the word has its own flops, so no bit has two writers
  logic [12:0] fault_flags_r; // open-load, over-current, regulator short
  logic [5:0] wake_flags_r; // filtered wakes, pin and bus wake sources
  logic cold_flag_r; // power-on flag
  // reserved bits stay low; the word is rebuilt from the groups
  assign status_r = {2'h0, cold_flag_r, wake_flags_r, fault_flags_r};
  // set beats clear, so a fault in the clear cycle is kept
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      fault_flags_r <= 13'h0000;
    end else begin
      fault_flags_r[S_OL_LO +: 5] <= (clr_cmd ? 5'h00 : fault_flags_r[S_OL_LO +: 5])
                                   | ev_s_r[4:0];
      fault_flags_r[S_OC_LO +: 7] <= (clr_cmd ? 7'h00 : fault_flags_r[S_OC_LO +: 7])
                                   | ev_s_r[11:5];
      fault_flags_r[S_SHT] <= (!clr_cmd && fault_flags_r[S_SHT]) | ev_s_r[12];
    end
  end
  // wakes 13..16 follow the filter live; the two wake sources are sticky
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wake_flags_r <= 6'h00;
    end else begin
      wake_flags_r[3:0] <= wk.filtered;
      wake_flags_r[S_EXTWU - S_WU_LO] <= (!clr_cmd && wake_flags_r[S_EXTWU - S_WU_LO])
                                         | ev_s_r[17];
      wake_flags_r[S_BUSWU - S_WU_LO] <= (!clr_cmd && wake_flags_r[S_BUSWU - S_WU_LO])
                                         | ev_s_r[18];
    end
  end
  // power-on flag: reset is the power-on event; latched one cycle after
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cold_pend_r <= 1'b1;
      cold_flag_r <= 1'b0;
    end else begin
      cold_pend_r <= 1'b0;
      if (cold_pend_r) begin
        cold_flag_r <= 1'b1;
      end else if (frame_end || clr_cmd) begin
        cold_flag_r <= 1'b0;
      end
    end
  end
  // -----------------------------------------------------------
  // supply fault lockout
  // -----------------------------------------------------------
  // the supply fault bits themselves live in the second status word,
  // outside this bank; here only the latch that holds outputs off
  logic lockout_r;
  // a fault still present when the clear arrives latches again at once,
  // so outputs only come back once the supply is really good
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      lockout_r <= 1'b0;
    end else if (supply_fault && ctrl_r[F_LOCK]) begin
      lockout_r <= 1'b1;
    end else if (clr_cmd) begin
      lockout_r <= 1'b0;
    end else if (!ctrl_r[F_LOCK]) begin
      lockout_r <= 1'b0;
    end
  end
  // -----------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------
  // every output comes from a flop, so decode never glitches a pin
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      openload_threshold_high_out <= 4'h0;
      main_highside_recovery_out <= 1'b0;
      bus_master_pullup_off_out <= 1'b0;
      transmit_timeout_off_out <= 1'b0;
      reset_threshold_out <= 2'h0;
      bus_slew_low_out <= 1'b0;
      regulator_supervision_on_out <= 1'b1;
      outputs_enable_out <= 1'b1;
      relay_drivers_enable_out <= 1'b1;
      status_clear_out <= 1'b0;
      status_word_out <= STATUS_RESET;
      spi_do_out <= 1'b0;
    end else begin
      openload_threshold_high_out <= ctrl_r[F_OLT_LO +: 4]; // 1 = 8mA, 0 = 2mA
      main_highside_recovery_out <= ctrl_r[F_REC];
      bus_master_pullup_off_out <= ctrl_r[F_PU];
      transmit_timeout_off_out <= ctrl_r[F_TOUT];
      // reserved upper code is forced to the 4.35V/4.65V pair
      reset_threshold_out <= {1'b0, ctrl_r[F_RESET_THRESHOLD_SELECT_LOWER]};
      bus_slew_low_out <= ctrl_r[F_SLOPE];
      regulator_supervision_on_out <= !ctrl_r[F_REGULATOR_CURRENT_SUPERVISION_DISABLE];
      // outputs off during fault or while locked
      outputs_enable_out <= !supply_fault && !lockout_r;
      relay_drivers_enable_out <= ctrl_r[F_RELSD] || !supply_fault;
      status_clear_out <= clr_cmd;
      status_word_out <= status_r;
      spi_do_out <= do_r;
    end
  end
endmodule

// >>> cfsb_bank_monitor.sv
// checker: port-level properties of the config and fault status bank
`timescale 1ns/10ps
module cfsb_bank_monitor
  import cfsb_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_do_out,
  input wire logic supply_fault_in,
  input wire logic outputs_enable_out,
  input wire logic relay_drivers_enable_out,
  input wire logic regulator_supervision_on_out,
  input wire logic [1:0] reset_threshold_out,
  input wire logic status_clear_out,
  input wire logic [21:0] status_word_out
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // fault held long enough to pass the two-flop sync
  sequence fault_held;
    supply_fault_in [*8];
  endsequence
  // a clear strobe cycle followed by a cycle with the strobe low
  sequence clear_seen;
    status_clear_out ##1 !status_clear_out;
  endsequence
  a_reset_values: assert property (disable iff (1'b0) sys_rst_in |=>
    status_word_out == STATUS_RESET && outputs_enable_out && relay_drivers_enable_out
    && regulator_supervision_on_out) else $error("reset values wrong");
  a_reserved_zero: assert property (status_word_out[21:20] == 2'h0)
    else $error("reserved status bits set");
  a_level_upper: assert property (reset_threshold_out[1] == 1'b0)
    else $error("reserved reset level driven");
  a_fault_off: assert property (fault_held |-> !outputs_enable_out)
    else $error("outputs on during supply fault");
  a_clear_pulse: assert property (status_clear_out |-> spi_cs_n_in ##1 !status_clear_out)
    else $error("clear strobe malformed");
  a_clear_wipe: assert property (clear_seen |-> ##[0:1] (status_word_out[12:0] == 13'h0
    && status_word_out[19:17] == 3'h0)) else $error("clear left status bits");
  a_flags_sticky: assert property (|($past(status_word_out[12:0]) & ~status_word_out[12:0])
    |-> $past(status_clear_out) || $past(status_clear_out, 2)) else $error("fault flag dropped");
  a_cold_clear: assert property ($fell(status_word_out[S_COLD]) |-> spi_cs_n_in)
    else $error("power-on flag cleared inside frame");
  a_cold_set: assert property ($fell(sys_rst_in) |-> ##[1:4] status_word_out[S_COLD])
    else $error("power-on flag not set");
  a_do_steady: assert property (!spi_cs_n_in && spi_clk_in && $past(spi_clk_in)
    && $past(spi_clk_in, 2) |-> $stable(spi_do_out)) else $error("data out moved on high clock");
endmodule
bind cfsb_bank cfsb_bank_monitor u_mon (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_clk_in(spi_clk_in), .spi_do_out(spi_do_out),
  .supply_fault_in(supply_fault_in), .outputs_enable_out(outputs_enable_out),
  .relay_drivers_enable_out(relay_drivers_enable_out),
  .regulator_supervision_on_out(regulator_supervision_on_out),
  .reset_threshold_out(reset_threshold_out), .status_clear_out(status_clear_out),
  .status_word_out(status_word_out));

// >>> cfsb_host_model.sv
// partner: serial host that frames control words and collects the status word
`timescale 1ns/10ps
module cfsb_host_model (
  input wire logic clock_in,
  input wire logic spi_do_in,
  output logic spi_cs_n_out,
  output logic spi_clk_out,
  output logic spi_di_out
);
  // idle: deselected, clock parked low
  initial begin
    spi_cs_n_out = 1'b1;
    spi_clk_out = 1'b0;
    spi_di_out = 1'b0;
  end
  // one frame, msb first, serial period of 8 system clocks (320 ns)
  task automatic xfer(input logic [1:0] a, input logic [21:0] d, input int n,
                      output logic [21:0] rd);
    logic [23:0] f;
    f = {a, d};
    rd = 22'h000000;
    @(posedge clock_in) spi_cs_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      spi_di_out <= f[23 - i];
      repeat (4) @(posedge clock_in);
      spi_clk_out <= 1'b1;
      // status bits come from the third rising edge on; looked at mid-high
      // because the bit launched by the last falling edge lands on this edge
      repeat (2) @(posedge clock_in);
      if (i >= 2) rd[23 - i] = spi_do_in;
      repeat (2) @(posedge clock_in);
      spi_clk_out <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    spi_cs_n_out <= 1'b1;
    // released line must not keep its last level
    spi_di_out <= ~spi_di_out;
    // gap lets the decoded word land before the caller looks
    repeat (8) @(posedge clock_in);
  endtask
endmodule

// >>> config_and_fault_status_bank_tb.sv
// testbench: config decode, status word, clear and wake filtering
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module config_and_fault_status_bank_tb;
  import cfsb_pkg::*;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, cs_n, sclk, sdi, sdo, ext_wk = 0, bus_wk = 0;
  logic olm = 0, ocm = 0, sht = 0, sf = 0, oe, rel_en, sup_on, pu, tout, rec, slew, clr;
  logic [3:0] ol4 = 0, oc4 = 0, wk = 0, wst = 0, olt;
  logic [1:0] rel_oc = 0, lev;
  logic [21:0] st, exp_st, rd, c, seed = 22'h000009;
  int bad_count = 0, comparisons = 0, cycles = 0, clr_seen = 0;
  // ----------------------------------------
  // clock, watchdog, stimulus helpers
  // ----------------------------------------
  always #20 clock_in = ~clock_in;
  // whole run is about 25k cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (clr === 1'b1) clr_seen <= clr_seen + 1;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end
  function automatic logic [21:0] lfsr(input logic [21:0] s);
    return {s[20:0], s[21] ^ s[20]};
  endfunction
  cfsb_bank uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .spi_cs_n_in(cs_n),
    .spi_clk_in(sclk), .spi_di_in(sdi), .spi_do_out(sdo), .small_highside_openload_in(ol4),
    .main_highside_openload_in(olm), .small_highside_overcurrent_in(oc4),
    .main_highside_overcurrent_in(ocm), .relay_overcurrent_in(rel_oc),
    .second_regulator_short_in(sht), .wake_input_in(wk), .wake_cycle_start_in(wst),
    .external_pin_wake_in(ext_wk), .bus_wake_in(bus_wk), .supply_fault_in(sf),
    .openload_threshold_high_out(olt), .main_highside_recovery_out(rec),
    .bus_master_pullup_off_out(pu), .transmit_timeout_off_out(tout), .reset_threshold_out(lev),
    .bus_slew_low_out(slew), .regulator_supervision_on_out(sup_on), .outputs_enable_out(oe),
    .relay_drivers_enable_out(rel_en), .status_clear_out(clr), .status_word_out(st));
  cfsb_host_model host (.clock_in(clock_in), .spi_do_in(sdo), .spi_cs_n_out(cs_n),
    .spi_clk_out(sclk), .spi_di_out(sdi));
  // frame plus readback check against the model
  task automatic send(input logic [1:0] a, input logic [21:0] d, input int n);
    host.xfer(a, d, n, rd);
    if (n == FRAME_BITS && a != ADDR_CW1) `CHK("readback", exp_st, rd)
    exp_st[S_COLD] = 1'b0;
    if (a == ADDR_CW1 && d[CLR_BIT]) exp_st = STATUS_RESET;
  endtask
  task automatic check_cfg(input logic [21:0] k);
    `CHK("threshold", k[3:0], olt)
    `CHK("recovery", k[F_REC], rec)
    `CHK("pullup", k[F_PU], pu)
    `CHK("timeout", k[F_TOUT], tout)
    `CHK("level", {1'b0, k[F_RESET_THRESHOLD_SELECT_LOWER]}, lev)
    `CHK("slew", k[F_SLOPE], slew)
    `CHK("supervision", ~k[F_REGULATOR_CURRENT_SUPERVISION_DISABLE], sup_on)
    `CHK("status", exp_st, st)
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    exp_st = 22'h000000;
    exp_st[S_COLD] = 1'b1;
    check_cfg(CTRL_RESET);
    `CHK("enable", 2'h3, {oe, rel_en})
    // random configuration words; host keeps the reserved level bit low
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(lfsr(lfsr(seed)));
      c = seed & 22'h1FFDFF;
      send(ADDR_CW2, c, FRAME_BITS);
      check_cfg(c);
    end
    // short frame must leave the configuration alone
    send(ADDR_CW2, ~c & 22'h1FFDFF, 20);
    check_cfg(c);
    // fault events pulse then vanish; flags must stay
    seed = lfsr(seed);
    {sht, rel_oc, ocm, oc4, olm, ol4} <= seed[12:0];
    {bus_wk, ext_wk} <= seed[14:13];
    repeat (4) @(posedge clock_in);
    {sht, rel_oc, ocm, oc4, olm, ol4, bus_wk, ext_wk} <= 15'h0000;
    repeat (8) @(posedge clock_in);
    exp_st = {3'h0, seed[14:13], 4'h0, seed[12:0]};
    `CHK("faults", exp_st, st)
    send(ADDR_CW0, 22'h000000, FRAME_BITS);
    `CHK("sticky", exp_st, st)
    send(ADDR_CW1, 22'h200000, FRAME_BITS);
    `CHK("cleared", exp_st, st)
    `CHK("clear strobe", 1, clr_seen)
    // supply fault: auto recovery, relay hold, then lockout
    for (int k = 0; k < 3; k++) begin
      c = 22'h000000;
      c[F_LOCK] = (k == 2);
      c[F_RELSD] = (k == 1);
      send(ADDR_CW2, c, FRAME_BITS);
      sf <= 1'b1;
      repeat (10) @(posedge clock_in);
      `CHK("oe fault", 1'b0, oe)
      `CHK("relay fault", c[F_RELSD], rel_en)
      sf <= 1'b0;
      repeat (10) @(posedge clock_in);
      `CHK("oe after", ~c[F_LOCK], oe)
      send(ADDR_CW1, 22'h200000, FRAME_BITS);
      `CHK("oe cleared", 1'b1, oe)
    end
    // wake codes 00,01,10,11 on inputs 1..4
    c = 22'h000000;
    c[F_IC_LO +: 8] = {WF_T1_LONG, WF_T2_LONG, WF_T2_SHORT, WF_STATIC};
    send(ADDR_CW2, c, FRAME_BITS);
    wk <= 4'hF;
    wst <= 4'hF;
    @(posedge clock_in) wst <= 4'h0;
    repeat (1000) @(posedge clock_in);
    `CHK("wake early", 4'h0, st[16:13])
    repeat (2000) @(posedge clock_in);
    `CHK("wake short", 4'h3, st[16:13])
    repeat (19500) @(posedge clock_in);
    `CHK("wake long", 4'hF, st[16:13])
    final_report();
  end
endmodule
